//--- mdd_datapath.sv
/*
  multiply/divide execution datapath: dual halfword multiplies, halfword and
  word-by-halfword multiplies, long multiply with accumulate, iterative divide.
  assumes the decoder holds req_i steady while busy and never issues the
  stack pointer or program counter as operand or destination.
*/
// Notes on behaviour
// RULE1 - dual multiply-add: two signed halfword products summed into destination
// RULE2 - exchange variants swap the second operand's halfwords first
// RULE3 - plain pairs low/low and high/high; exchange pairs low/high, high/low
// RULE4 - dual multiply-subtract: low product minus high product
// RULE5 - dual multiply-add sets sticky saturation flag on final-add overflow
// RULE6 - saturation flag only set, never cleared; subtract forms leave it
// RULE7 - first select low takes bits 15:0, high takes bits 31:16
// RULE8 - second select low takes bits 15:0, high takes bits 31:16
// RULE9 - halfword multiply writes full signed 32-bit product
// RULE10 - word-by-halfword writes upper 32 bits of 48-bit product
// RULE11 - long multiply: 64-bit product, low and high destinations
// RULE12 - long accumulate adds product to 64-bit destination pair
// RULE13 - long forms leave condition flags unchanged
// RULE14 - divide first source by second, signed or unsigned
// RULE15 - quotient truncates toward zero
// RULE16 - divides change no processor flags
// RULE17 - issuer never selects stack pointer or program counter
`timescale 1ns/1ns
module mdd_datapath
(
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  // request
  input  wire logic             start_i,
  input  wire mdd_pkg::mdd_req_t req_i,
  // answer
  output logic                  busy_o,
  output logic                  done_o,
  output mdd_pkg::mdd_rsp_t     rsp_o,
  output logic                  sat_flag_o
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_n_q;

  // two-stage release of asynchronous reset
  always_ff @(posedge ref_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    mdd_pkg::mdd_state_t st;
    mdd_pkg::mdd_rsp_t   rsp;
    logic                sat;
    logic [5:0]          cnt;
    logic [31:0]         rem;
    logic [31:0]         quo;
    logic [31:0]         dvs;
    logic                neg_q;
  } mdd_regs_t;

  mdd_regs_t s_q;
  mdd_regs_t s_d;

  // ****************************************
  // combinational arithmetic
  // ****************************************
  logic signed [15:0] a_lo, a_hi, b_lo, b_hi, b_p0, b_p1, h_a, h_b;
  logic signed [31:0] p_lo, p_hi, p_half;
  logic signed [32:0] dual_sum;
  logic signed [47:0] p_wh;
  logic        [63:0] long_prod, long_res;
  logic        [31:0] dvd_abs, dvs_abs;
  logic        [32:0] trial;

  always_comb
  begin
    a_lo = req_i.first_src[15:0];
    a_hi = req_i.first_src[31:16];
    b_lo = req_i.second_src[15:0];
    b_hi = req_i.second_src[31:16];
    // exchange swaps second operand halves
    b_p0 = req_i.op[0] ? b_hi : b_lo;  // RULE2 RULE3
    b_p1 = req_i.op[0] ? b_lo : b_hi;  // RULE2 RULE3
    p_lo = a_lo * b_p0;  // RULE1
    p_hi = a_hi * b_p1;  // RULE1
    if (req_i.op inside {mdd_pkg::OP_DUAL_MUL_SUB, mdd_pkg::OP_DUAL_MUL_SUB_X})
      dual_sum = 33'(p_lo) - 33'(p_hi);  // RULE4
    else
      dual_sum = 33'(p_lo) + 33'(p_hi);  // RULE1
    h_a    = req_i.sel_first_high  ? a_hi : a_lo;  // RULE7
    h_b    = req_i.sel_second_high ? b_hi : b_lo;  // RULE8
    p_half = h_a * h_b;  // RULE9
    p_wh   = 48'($signed(req_i.first_src)) * 48'(h_b);  // RULE10
    if (req_i.op inside {mdd_pkg::OP_SIGNED_LONG_MUL, mdd_pkg::OP_SIGNED_LONG_MACC})
      long_prod = 64'($signed(64'($signed(req_i.first_src)))
                      * $signed(64'($signed(req_i.second_src))));  // RULE11
    else
      long_prod = 64'(req_i.first_src) * 64'(req_i.second_src);  // RULE11
    if (req_i.op inside {mdd_pkg::OP_SIGNED_LONG_MACC, mdd_pkg::OP_UNSIGNED_LONG_MACC})
      long_res = long_prod + {req_i.acc_high, req_i.acc_low};  // RULE12
    else
      long_res = long_prod;
    // magnitudes for divider
    dvd_abs = (req_i.op == mdd_pkg::OP_SIGNED_DIVIDE && req_i.first_src[31])
              ? 32'(-req_i.first_src) : req_i.first_src;  // RULE14
    dvs_abs = (req_i.op == mdd_pkg::OP_SIGNED_DIVIDE && req_i.second_src[31])
              ? 32'(-req_i.second_src) : req_i.second_src;  // RULE14
    trial = {s_q.rem, s_q.quo[31]} - {1'b0, s_q.dvs};
  end

  // next-state logic
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      mdd_pkg::ST_IDLE, mdd_pkg::ST_DONE:
      begin
        s_d.st             = mdd_pkg::ST_IDLE;
        s_d.rsp.write_high = 1'b0;
        s_d.rsp.sat_set    = 1'b0;
        if (start_i)
        begin
          s_d.st = mdd_pkg::ST_DONE;
          s_d.rsp.result_high = mdd_pkg::RESULT_RESET;
          case (req_i.op)
            mdd_pkg::OP_DUAL_MUL_ADD, mdd_pkg::OP_DUAL_MUL_ADD_X:
            begin
              s_d.rsp.result_low = dual_sum[31:0];  // RULE1
              s_d.rsp.sat_set    = dual_sum[32] ^ dual_sum[31];  // RULE5
              s_d.sat            = s_q.sat | s_d.rsp.sat_set;  // RULE5 RULE6
            end
            mdd_pkg::OP_DUAL_MUL_SUB, mdd_pkg::OP_DUAL_MUL_SUB_X:
              s_d.rsp.result_low = dual_sum[31:0];  // RULE4 RULE6
            mdd_pkg::OP_HALF_MUL:
              s_d.rsp.result_low = p_half;  // RULE9
            mdd_pkg::OP_WORD_HALF_MUL:
              s_d.rsp.result_low = p_wh[47:16];  // RULE10
            mdd_pkg::OP_SIGNED_DIVIDE, mdd_pkg::OP_UNSIGNED_DIVIDE:
            begin
              s_d.st    = mdd_pkg::ST_DIV;  // RULE16
              s_d.rem   = 32'h0;
              s_d.quo   = dvd_abs;
              s_d.dvs   = dvs_abs;
              s_d.cnt   = mdd_pkg::DIV_STEPS;
              s_d.neg_q = (req_i.op == mdd_pkg::OP_SIGNED_DIVIDE)
                          && (req_i.first_src[31] ^ req_i.second_src[31]);
            end
            default:
            begin
              s_d.rsp.result_low  = long_res[31:0];  // RULE11 RULE13
              s_d.rsp.result_high = long_res[63:32];  // RULE11 RULE12
              s_d.rsp.write_high  = 1'b1;
            end
          endcase
        end
      end
      mdd_pkg::ST_DIV:
      begin
        // restoring step, magnitudes give truncation toward zero
        if (!trial[32])
        begin
          s_d.rem = trial[31:0];
          s_d.quo = {s_q.quo[30:0], 1'b1};  // RULE15
        end
        else
        begin
          s_d.rem = {s_q.rem[30:0], s_q.quo[31]};
          s_d.quo = {s_q.quo[30:0], 1'b0};  // RULE15
        end
        s_d.cnt = 6'(s_q.cnt - 6'h1);
        if (s_q.cnt == 6'h1)
        begin
          s_d.st = mdd_pkg::ST_DONE;
          // zero divisor gives all-ones magnitude; no trap raised
          s_d.rsp.result_low = s_q.neg_q ? 32'(-s_d.quo) : s_d.quo;  // RULE14 RULE15
        end
      end
      default:
        s_d.st = mdd_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // outputs
  assign busy_o     = (s_q.st == mdd_pkg::ST_DIV);
  assign done_o     = (s_q.st == mdd_pkg::ST_DONE);
  assign rsp_o      = s_q.rsp;
  assign sat_flag_o = s_q.sat;

  // ****************************************
  // assertions
  // ****************************************
  a_sat_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q) // RULE6
    $past(sat_flag_o) |-> sat_flag_o)
    else $error("saturation flag cleared");
  a_sub_no_sat: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q) // RULE6
    (start_i && !busy_o && req_i.op inside {mdd_pkg::OP_DUAL_MUL_SUB,
      mdd_pkg::OP_DUAL_MUL_SUB_X}) |=> (sat_flag_o == $past(sat_flag_o)))
    else $error("subtract changed saturation flag");
  a_add_result: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q) // RULE1
    (start_i && !busy_o && req_i.op == mdd_pkg::OP_DUAL_MUL_ADD) |=>
      done_o && rsp_o.result_low == 32'($past(p_lo) + $past(p_hi)))
    else $error("dual add result wrong");
  a_add_ovf: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q) // RULE5
    (done_o && rsp_o.sat_set) |-> sat_flag_o)
    else $error("overflow did not set flag");
  a_half_prod: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q) // RULE9
    (start_i && !busy_o && req_i.op == mdd_pkg::OP_HALF_MUL) |=>
      rsp_o.result_low == 32'(32'($past(h_a)) * 32'($past(h_b))))
    else $error("halfword product wrong");
  a_long_pair: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q) // RULE11
    (start_i && !busy_o && req_i.op == mdd_pkg::OP_UNSIGNED_LONG_MUL) |=>
      {rsp_o.result_high, rsp_o.result_low}
        == 64'($past(req_i.first_src)) * 64'($past(req_i.second_src)) && rsp_o.write_high)
    else $error("long product wrong");
  a_div_time: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q) // RULE14
    (start_i && !busy_o && req_i.op == mdd_pkg::OP_UNSIGNED_DIVIDE) |=>
      busy_o ##32 done_o)
    else $error("divide latency wrong");
  a_div_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_q) // RULE16
    busy_o |=> $stable(sat_flag_o))
    else $error("divide touched flag");
  c_dual_ovf: cover property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    done_o && rsp_o.sat_set);
  c_div_done: cover property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    busy_o ##1 done_o);
  c_long: cover property (@(posedge ref_clk_i) disable iff (!rst_n_q)
    done_o && rsp_o.write_high);

endmodule

//--- mdd_datapath_test.sv
/*
  self-checking bench for the multiply/divide datapath.
  assumes mdd_pkg, mdd_datapath and mdd_issuer are compiled first.
*/
`timescale 1ns/1ns
module mdd_datapath_test;
  logic              ref_clk_i;
  logic              nrst_i;
  logic              start_i;
  logic              busy_o;
  logic              done_o;
  logic              sat_flag_o;
  mdd_pkg::mdd_req_t req_i;
  mdd_pkg::mdd_rsp_t rsp_o;
  mdd_pkg::mdd_rsp_t rs;
  int                fail_count = 0;
  int                num_checks = 0;

  mdd_datapath DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .start_i(start_i), .req_i(req_i),
                    .busy_o(busy_o), .done_o(done_o), .rsp_o(rsp_o), .sat_flag_o(sat_flag_o));
  mdd_issuer PEER (.ref_clk_i(ref_clk_i), .busy_i(busy_o), .done_i(done_o), .rsp_i(rsp_o),
                   .start_o(start_i), .req_o(req_i));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic run(input mdd_pkg::mdd_op_t op, input logic sf, input logic ss,
                     input logic [31:0] a, input logic [31:0] b, input logic [63:0] acc);
    mdd_pkg::mdd_req_t r;
    logic              got;
    r = '{op, sf, ss, a, b, acc[63:32], acc[31:0]};
    PEER.issue(r, rs, got);
    chk({63'h0, got}, 64'h1);
  endtask

  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_dual;
    logic [31:0] e [4] = '{32'h1, 32'hb, 32'hffffffe3, 32'hffffffe1};
    for (int i = 0; i < 4; i++)
    begin
      run(mdd_pkg::mdd_op_t'(i), 1'b0, 1'b0, 32'h0003fffe, 32'h00050007, 64'h0);
      chk({32'h0, rs.result_low}, {32'h0, e[i]});
      chk({62'h0, rs.sat_set, sat_flag_o}, 64'h0);
      chk({PEER.busy_cnt, PEER.lat_cnt}, 64'h0);
    end
  endtask

  task automatic t_half;
    logic signed [15:0] x, y;
    logic signed [31:0] p;
    logic signed [47:0] w;
    for (int i = 0; i < 4; i++)
    begin
      x = i[1] ? 16'sh8000 : 16'sh7fff;
      y = i[0] ? 16'shfffe : 16'sh0003;
      p = x * y;
      w = $signed(32'h80007fff) * y;
      run(mdd_pkg::OP_HALF_MUL, i[1], i[0], 32'h80007fff, 32'hfffe0003, 64'h0);
      chk({32'h0, rs.result_low}, {32'h0, p});
      run(mdd_pkg::OP_WORD_HALF_MUL, 1'b0, i[0], 32'h80007fff, 32'hfffe0003, 64'h0);
      chk({32'h0, rs.result_low}, {32'h0, w[47:16]});
    end
  endtask

  task automatic t_sat;
    run(mdd_pkg::OP_DUAL_MUL_ADD, 1'b0, 1'b0, 32'h80008000, 32'h80008000, 64'h0);
    chk({rs.result_low, 30'h0, rs.sat_set, sat_flag_o}, {32'h80000000, 32'h3});
    run(mdd_pkg::OP_DUAL_MUL_SUB, 1'b0, 1'b0, 32'h80008000, 32'h80008000, 64'h0);
    chk({rs.result_low, 30'h0, rs.sat_set, sat_flag_o}, {32'h0, 32'h1});
  endtask

  task automatic t_long;
    logic [63:0] u, s, acc;
    acc = 64'h00000001ffffffff;
    u   = {32'h0, 32'hfffffffe} * 64'h3;
    s   = $signed(32'hfffffffe) * $signed(32'h3);
    for (int i = 0; i < 4; i++)
    begin
      run(mdd_pkg::mdd_op_t'(6 + i), 1'b0, 1'b0, 32'hfffffffe, 32'h3, acc);
      chk({rs.result_high, rs.result_low}, (i < 2 ? u : s) + (i[0] ? acc : 64'h0));
      chk({62'h0, rs.write_high, sat_flag_o}, 64'h3);
    end
  endtask

  task automatic t_div;
    logic [31:0] a [5] = '{32'hfffffff9, 32'h7, 32'hfffffff9, 32'hfffffff9, 32'h64};
    logic [31:0] b [5] = '{32'h2, 32'hfffffffe, 32'hfffffffe, 32'h2, 32'h7};
    logic [31:0] q;
    for (int i = 0; i < 5; i++)
    begin
      // separate branches: a mixed conditional would turn the signed divide unsigned
      if (i < 3)
        q = $signed(a[i]) / $signed(b[i]);
      else
        q = a[i] / b[i];
      run(i < 3 ? mdd_pkg::OP_SIGNED_DIVIDE : mdd_pkg::OP_UNSIGNED_DIVIDE, 1'b0, 1'b0,
          a[i], b[i], 64'h0);
      chk({32'h0, rs.result_low}, {32'h0, q});
      chk({PEER.busy_cnt, PEER.lat_cnt}, {32'h20, 32'h20});
      chk({63'h0, sat_flag_o}, 64'h1);
    end
  endtask

  // ****************************************
  // clock, main sequence, watchdog
  // ****************************************
  // free-running 20 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // reset, then scenarios in an order that keeps the sticky flag meaningful
  initial
  begin
    nrst_i = 1'b0;
    repeat (10) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    t_dual;
    t_half;
    t_sat;
    t_long;
    t_div;
    end_sim;
  end

  // cut a hang short
  initial
  begin
    #(5000 * 50);
    fail_count++;
    end_sim;
  end
endmodule

//--- mdd_issuer.sv
/*
  issuing-side model: drives one request at a time into the datapath
  and collects its answer.
  assumes inputs change at the falling edge and a single core clock.
*/
`timescale 1ns/1ns
module mdd_issuer
(
  // clock
  input  wire logic              ref_clk_i,
  // answer from datapath
  input  wire logic              busy_i,
  input  wire logic              done_i,
  input  wire mdd_pkg::mdd_rsp_t rsp_i,
  // request to datapath
  output logic                   start_o,
  output mdd_pkg::mdd_req_t      req_o
);
  // cycles waited for the answer and cycles seen busy, read by the bench
  int lat_cnt;
  int busy_cnt;

  // idle values at time zero
  initial
  begin
    start_o = 1'b0;
    req_o   = '0;
  end

  // one request, held until its answer, then operands scrambled
  task automatic issue(input mdd_pkg::mdd_req_t r, output mdd_pkg::mdd_rsp_t rs,
                       output logic got);
    int n;
    got = 1'b0;
    rs  = '0;
    n   = 0;
    busy_cnt = 0;
    @(negedge ref_clk_i);
    while (busy_i !== 1'b0)
      @(negedge ref_clk_i);
    start_o = 1'b1;
    req_o   = r;
    @(negedge ref_clk_i);
    start_o = 1'b0;
    while (got === 1'b0 && n < 40)
    begin
      if (done_i === 1'b1)
      begin
        got = 1'b1;
        rs  = rsp_i;
      end
      else
      begin
        if (busy_i === 1'b1)
          busy_cnt++;
        @(negedge ref_clk_i);
        n++;
      end
    end
    lat_cnt = n;
    req_o = ~r;
  endtask
endmodule

//--- mdd_pkg.sv
/*
  package for the multiply/divide datapath: operation codes, request and
  answer carriers, divider constants.
  assumes a single core clock; no other file dependencies.
*/
package mdd_pkg;

  // ****************************************
  // operation codes
  // ****************************************
  typedef enum logic [3:0] {
    OP_DUAL_MUL_ADD       = 4'h0,
    OP_DUAL_MUL_ADD_X     = 4'h1,
    OP_DUAL_MUL_SUB       = 4'h2,
    OP_DUAL_MUL_SUB_X     = 4'h3,
    OP_HALF_MUL           = 4'h4,
    OP_WORD_HALF_MUL      = 4'h5,
    OP_UNSIGNED_LONG_MUL  = 4'h6,
    OP_UNSIGNED_LONG_MACC = 4'h7,
    OP_SIGNED_LONG_MUL    = 4'h8,
    OP_SIGNED_LONG_MACC   = 4'h9,
    OP_SIGNED_DIVIDE      = 4'ha,
    OP_UNSIGNED_DIVIDE    = 4'hb
  } mdd_op_t;

  // ****************************************
  // constants
  // ****************************************
  localparam int          DATA_W       = 32;
  localparam logic [5:0]  DIV_STEPS    = 6'h20;  // one quotient bit per cycle
  localparam logic [31:0] RESULT_RESET = 32'h0;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    mdd_op_t     op;
    logic        sel_first_high;   // halfword select for first operand
    logic        sel_second_high;  // halfword select for second operand
    logic [31:0] first_src;
    logic [31:0] second_src;
    logic [31:0] acc_high;
    logic [31:0] acc_low;
  } mdd_req_t;

  typedef struct packed {
    logic [31:0] result_low;   // destination or low destination
    logic [31:0] result_high;  // high destination for long forms
    logic        write_high;   // high destination is written
    logic        sat_set;      // sets sticky saturation flag
  } mdd_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_DONE = 2'b10
  } mdd_state_t;

endpackage
